// *** design/rtcis_slave.v ***
// Two-wire bus slave of a clock/calendar, with interface watchdog.
// Assumes SCL and SDA are pins sampled by clk, and that the register
// core on clk answers rd_data combinationally for rd_addr.
`timescale 1ns/1ps
`include "rtcis_map.vh"

// Contract
// - SDA changes while SCL high are control conditions, never data.
// - SDA falling while SCL high is a start; the device detects it.
// - SDA rising while SCL high is a stop; it ends the transfer.
// - Each byte has eight bits plus one acknowledge clock, unlimited count.
// - An addressed receiving device acknowledges every received byte; a data byte that meets a full write buffer gets no acknowledge.
// - The acknowledger holds SDA low through the whole acknowledge high.
// - No master acknowledge: the device releases SDA for the stop.
// - The first byte after start is the address; respond only on match.
// - Device is slave only: never drives SCL, SDA is bidirectional.
// - Only the low four word-address bits select the register.
// - Time counting is frozen while an access is in progress.
// - Interface active over one second: clear it and resume counting.
// - A start or stop stops the watchdog.
// - The watchdog fires between one and two seconds after the address.
// - Each watchdog timeout costs the time counters one second.
module rtcis_slave #(
  parameter [6:0] DEV_ADDR = `RTCIS_DEV_ADDR,
  parameter WDT_CYCLES = `RTCIS_WDT_CYCLES,
  parameter TICK_W = 26
) (
  input wire clk,
  input wire rstn,
  input wire scl_i,
  input wire sda_i,
  output wire sda_o,
  output wire sda_oe,
  output wire wr_valid,
  input wire wr_ready,
  output wire [3:0] wr_addr,
  output wire [7:0] wr_data,
  output wire [3:0] rd_addr,
  input wire [7:0] rd_data,
  output wire freeze,
  output wire wdt_expired
);
  // ----------------------------------------------------------------
  // States and byte kinds
  // ----------------------------------------------------------------
  localparam [5:0] S_IDLE = 6'h01;
  localparam [5:0] S_RX = 6'h02;
  localparam [5:0] S_ACK = 6'h04;
  localparam [5:0] S_TX = 6'h08;
  localparam [5:0] S_MACK = 6'h10;
  localparam [5:0] S_WAIT = 6'h20;
  localparam [2:0] K_ADDR = 3'h1;
  localparam [2:0] K_WADR = 3'h2;
  localparam [2:0] K_DATA = 3'h4;
  // The period is cut to the counter width on purpose; TICK_W must be
  // wide enough to hold WDT_CYCLES - 1.
  localparam integer TICK_LAST_I = WDT_CYCLES - 1;
  localparam [TICK_W-1:0] TICK_LAST = TICK_LAST_I[TICK_W-1:0];

  // ----------------------------------------------------------------
  // Pin sampling and bus conditions
  // ----------------------------------------------------------------
  wire scl_s;
  wire sda_s;
  reg scl_d_reg;
  reg sda_d_reg;

  rtcis_sync #(
    .W(2)
  ) u_sync (
    .clk(clk),
    .rstn(rstn),
    .d({scl_i, sda_i}),
    .q({scl_s, sda_s})
  );

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      scl_d_reg <= 1'b1;
      sda_d_reg <= 1'b1;
    end else begin
      scl_d_reg <= scl_s;
      sda_d_reg <= sda_s;
    end
  end

  // SDA moving while SCL stays high is a condition, not a data bit.
  wire scl_hi = scl_s & scl_d_reg;
  wire start_det = scl_hi & sda_d_reg & ~sda_s;
  wire stop_det = scl_hi & ~sda_d_reg & sda_s;
  wire scl_rise = scl_s & ~scl_d_reg;
  wire scl_fall = ~scl_s & scl_d_reg;

  // ----------------------------------------------------------------
  // Write buffer towards the register core
  // ----------------------------------------------------------------
  reg push_reg;
  reg [11:0] push_word_reg;
  wire push_ready;

  rtcis_buf #(
    .W(12)
  ) u_buf (
    .clk(clk),
    .rstn(rstn),
    .in_valid(push_reg),
    .in_ready(push_ready),
    .in_data(push_word_reg),
    .out_valid(wr_valid),
    .out_ready(wr_ready),
    .out_data({wr_addr, wr_data})
  );

  // ----------------------------------------------------------------
  // Watchdog time base
  // ----------------------------------------------------------------
  // The tick runs free, so the first tick after the address lands
  // anywhere in the first second; two ticks give one to two seconds.
  reg [TICK_W-1:0] tick_cnt_reg;
  reg tick_reg;
  reg wdt_run_reg;
  reg [1:0] wdt_cnt_reg;
  wire wdt_fire = wdt_run_reg & (wdt_cnt_reg == `RTCIS_WDT_TICKS);

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tick_cnt_reg <= {TICK_W{1'b0}};
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= (tick_cnt_reg == TICK_LAST);
      if (tick_cnt_reg == TICK_LAST) begin
        tick_cnt_reg <= {TICK_W{1'b0}};
      end else begin
        tick_cnt_reg <= tick_cnt_reg + {{(TICK_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // ----------------------------------------------------------------
  // Byte engine
  // ----------------------------------------------------------------
  reg [5:0] state_reg;
  reg [2:0] kind_reg;
  reg [3:0] bit_cnt_reg;
  reg [7:0] shift_reg;
  reg [3:0] ptr_reg;
  reg read_reg;
  reg mack_reg;
  reg oe_reg;
  reg freeze_reg;
  reg expired_reg;
  wire [7:0] rx_byte = {shift_reg[6:0], sda_s};

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= S_IDLE;
      kind_reg <= K_ADDR;
      bit_cnt_reg <= 4'h0;
      shift_reg <= `RTCIS_SHIFT_RST;
      ptr_reg <= `RTCIS_WADR_RST;
      read_reg <= 1'b0;
      mack_reg <= 1'b0;
      oe_reg <= 1'b0;
      freeze_reg <= 1'b0;
      expired_reg <= 1'b0;
      push_reg <= 1'b0;
      push_word_reg <= 12'h000;
      wdt_run_reg <= 1'b0;
      wdt_cnt_reg <= 2'h0;
    end else begin
      push_reg <= 1'b0;
      expired_reg <= 1'b0;
      if (wdt_run_reg && tick_reg) begin
        wdt_cnt_reg <= wdt_cnt_reg + 2'h1;
      end
      if (wdt_fire) begin
        // Releasing here lets the frozen counters run again; the second
        // they missed while frozen is not made up.
        state_reg <= S_IDLE;
        oe_reg <= 1'b0;
        freeze_reg <= 1'b0;
        wdt_run_reg <= 1'b0;
        expired_reg <= 1'b1;
      end else if (start_det || stop_det) begin
        wdt_run_reg <= 1'b0;
        freeze_reg <= 1'b0;
        oe_reg <= 1'b0;
        bit_cnt_reg <= 4'h0;
        kind_reg <= K_ADDR;
        state_reg <= start_det ? S_RX : S_IDLE;
      end else begin
        case (state_reg)
          S_IDLE, S_WAIT: begin
            oe_reg <= 1'b0;
          end
          S_RX: begin
            if (scl_rise) begin
              shift_reg <= rx_byte;
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end else if (scl_fall &&
                         bit_cnt_reg == `RTCIS_BYTE_BITS) begin
              bit_cnt_reg <= 4'h0;
              state_reg <= S_ACK;
              oe_reg <= 1'b1;
              case (kind_reg)
                K_ADDR: begin
                  if (shift_reg[`RTCIS_ADDR_MSB:`RTCIS_ADDR_LSB] ==
                      DEV_ADDR) begin
                    read_reg <= shift_reg[`RTCIS_RW_BIT];
                    freeze_reg <= 1'b1;
                    wdt_run_reg <= 1'b1;
                    wdt_cnt_reg <= 2'h0;
                  end else begin
                    oe_reg <= 1'b0;
                    state_reg <= S_WAIT;
                  end
                end
                K_WADR: begin
                  ptr_reg <= shift_reg[`RTCIS_WADR_MSB:0];
                end
                default: begin
                  if (push_ready) begin
                    push_reg <= 1'b1;
                    push_word_reg <= {ptr_reg, shift_reg};
                    ptr_reg <= ptr_reg + 4'h1;
                  end else begin
                    // A full buffer refuses the byte rather than drop it.
                    oe_reg <= 1'b0;
                  end
                end
              endcase
            end
          end
          S_ACK: begin
            if (scl_fall) begin
              if (kind_reg == K_ADDR && read_reg) begin
                shift_reg <= rd_data;
                oe_reg <= ~rd_data[7];
                state_reg <= S_TX;
              end else begin
                oe_reg <= 1'b0;
                state_reg <= S_RX;
              end
              if (kind_reg == K_ADDR) begin
                kind_reg <= K_WADR;
              end else begin
                kind_reg <= K_DATA;
              end
            end
          end
          S_TX: begin
            if (scl_fall) begin
              if (bit_cnt_reg[2:0] == `RTCIS_LAST_TX_BIT) begin
                bit_cnt_reg <= 4'h0;
                oe_reg <= 1'b0;
                ptr_reg <= ptr_reg + 4'h1;
                state_reg <= S_MACK;
              end else begin
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
                shift_reg <= {shift_reg[6:0], 1'b0};
                oe_reg <= ~shift_reg[6];
              end
            end
          end
          S_MACK: begin
            if (scl_rise) begin
              mack_reg <= ~sda_s;
            end else if (scl_fall) begin
              if (mack_reg) begin
                shift_reg <= rd_data;
                oe_reg <= ~rd_data[7];
                state_reg <= S_TX;
              end else begin
                oe_reg <= 1'b0;
                state_reg <= S_WAIT;
              end
            end
          end
          default: begin
            state_reg <= S_IDLE;
            oe_reg <= 1'b0;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Open drain: the pin is only ever pulled low, SCL is never driven.
  reg sda_o_reg;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sda_o_reg <= 1'b0;
    end else begin
      sda_o_reg <= 1'b0;
    end
  end

  assign sda_o = sda_o_reg;
  assign sda_oe = oe_reg;
  assign rd_addr = ptr_reg;
  assign freeze = freeze_reg;
  assign wdt_expired = expired_reg;
endmodule

// *** design/rtcis_map.vh ***
// Constants of the two-wire slave of the clock/calendar.
// Assumes inclusion by bare name from the design files.
`ifndef RTCIS_MAP_VH
`define RTCIS_MAP_VH

// Clock rate and watchdog period.
`define RTCIS_CLK_HZ 50000000
`define RTCIS_WDT_S 1
`define RTCIS_WDT_CYCLES (`RTCIS_WDT_S * `RTCIS_CLK_HZ)
// Ticks counted after a valid address before the watchdog fires.
`define RTCIS_WDT_TICKS 2'h2

// Slave address in the upper seven bits of the first byte.
`define RTCIS_DEV_ADDR 7'h50
`define RTCIS_RW_BIT 0
`define RTCIS_ADDR_MSB 7
`define RTCIS_ADDR_LSB 1

// Word address field and byte framing.
`define RTCIS_WADR_W 4
`define RTCIS_WADR_MSB 3
`define RTCIS_BYTE_BITS 4'h8
`define RTCIS_LAST_TX_BIT 3'h7

// Reset values.
`define RTCIS_WADR_RST 4'h0
`define RTCIS_SHIFT_RST 8'h00

`endif

// *** design/rtcis_sync.v ***
// Two-stage synchroniser for levels from outside the clock domain.
// Assumes the inputs are slow compared with clk.
`timescale 1ns/1ps
module rtcis_sync #(
  parameter W = 2
) (
  input wire clk,
  input wire rstn,
  input wire [W-1:0] d,
  output wire [W-1:0] q
);
  // Idle bus lines are high, so both stages reset high.
  reg [W-1:0] meta_reg;
  reg [W-1:0] sync_reg;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_reg <= {W{1'b1}};
      sync_reg <= {W{1'b1}};
    end else begin
      meta_reg <= d;
      sync_reg <= meta_reg;
    end
  end

  assign q = sync_reg;
endmodule

// *** design/rtcis_buf.v ***
// Two-entry buffer with valid and ready on both sides.
// Assumes producer and consumer share clk; output data is a flip-flop.
`timescale 1ns/1ps
module rtcis_buf #(
  parameter W = 12
) (
  input wire clk,
  input wire rstn,
  input wire in_valid,
  output wire in_ready,
  input wire [W-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [W-1:0] out_data
);
  reg head_v_reg;
  reg [W-1:0] head_reg;
  reg tail_v_reg;
  reg [W-1:0] tail_reg;
  wire push;
  wire pop;

  assign in_ready = ~tail_v_reg;
  assign push = in_valid & ~tail_v_reg;
  assign pop = head_v_reg & out_ready;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      head_v_reg <= 1'b0;
      tail_v_reg <= 1'b0;
      head_reg <= {W{1'b0}};
      tail_reg <= {W{1'b0}};
    end else if (!head_v_reg || pop) begin
      head_v_reg <= tail_v_reg | push;
      if (tail_v_reg) begin
        head_reg <= tail_reg;
      end else if (push) begin
        head_reg <= in_data;
      end
      tail_v_reg <= tail_v_reg & push;
      if (tail_v_reg && push) begin
        tail_reg <= in_data;
      end
    end else if (push) begin
      tail_v_reg <= 1'b1;
      tail_reg <= in_data;
    end
  end

  assign out_valid = head_v_reg;
  assign out_data = head_reg;
endmodule

// *** testbench/rtcis_monitor.sv ***
// Port assertions for the two-wire slave with interface watchdog.
// Assumes one clock domain and the slave's asynchronous active-low reset.
`timescale 1ns/1ps
module rtcis_monitor #(
  parameter WDT_CYCLES = 50000000
) (
  input wire clk,
  input wire rstn,
  input wire scl_i,
  input wire sda_i,
  input wire sda_o,
  input wire sda_oe,
  input wire wr_valid,
  input wire wr_ready,
  input wire [3:0] wr_addr,
  input wire [7:0] wr_data,
  input wire [3:0] rd_addr,
  input wire [7:0] rd_data,
  input wire freeze,
  input wire wdt_expired
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // ----------------------------------------------------------------
  // Frozen-cycle counter
  // ----------------------------------------------------------------
  // A counter is used because the watchdog window is far too long for
  // a repetition operator.
  reg [31:0] frz_cnt_reg;
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      frz_cnt_reg <= 32'h0;
    end else begin
      frz_cnt_reg <= freeze ? frz_cnt_reg + 32'h1 : 32'h0;
    end
  end
  a_sda_o_zero: assert property (sda_o == 1'h0)
    else $error("sda_o driven high");
  a_oe_stable_high: assert property
    (scl_i && $past(scl_i) |-> $stable(sda_oe))
    else $error("sda_oe moved while SCL high");
  a_freeze_ack: assert property ($rose(freeze) |-> sda_oe)
    else $error("freeze without address ack");
  a_word_hold: assert property
    (wr_valid && !wr_ready |=> wr_valid && $stable({wr_addr, wr_data}))
    else $error("write word lost under stall");
  a_wdt_pulse: assert property (wdt_expired |=> !wdt_expired)
    else $error("watchdog pulse too long");
  a_wdt_clears: assert property
    (wdt_expired |-> ##[0:1] (!freeze && !sda_oe))
    else $error("watchdog left interface busy");
  a_wdt_armed: assert property (wdt_expired |-> $past(freeze))
    else $error("watchdog fired while idle");
  a_wdt_window: assert property ($rose(wdt_expired) |->
    frz_cnt_reg >= WDT_CYCLES - 1 && frz_cnt_reg <= 2 * WDT_CYCLES + 2)
    else $error("watchdog outside its window");
  a_freeze_bound: assert property
    (frz_cnt_reg <= 2 * WDT_CYCLES + 2)
    else $error("interface stuck past watchdog");
endmodule

bind rtcis_slave rtcis_monitor #(.WDT_CYCLES(WDT_CYCLES)) rtcis_monitor_inst (
  .clk, .rstn, .scl_i, .sda_i, .sda_o, .sda_oe, .wr_valid, .wr_ready,
  .wr_addr, .wr_data, .rd_addr, .rd_data, .freeze, .wdt_expired);

// *** testbench/rtcis_master.sv ***
// Bus master model: drives SCL and its own open-drain SDA share.
// Assumes the bench resolves the SDA wire with a pull-up.
`timescale 1ns/1ps
module rtcis_master (
  input wire clk,
  input wire sda,
  output reg scl,
  output reg sda_m
);
  // ----------------------------------------------------------------
  // Bus cycles, SCL period 8 clocks: 5 low, 3 high
  // ----------------------------------------------------------------
  initial begin
    scl = 1'h1;
    sda_m = 1'h1;
  end
  task w(input integer n);
    repeat (n) @(negedge clk);
  endtask
  // Start, also usable as repeated start from SCL low.
  task st;
    begin
      sda_m = 1'h1;
      w(3);
      scl = 1'h1;
      w(3);
      sda_m = 1'h0;
      w(3);
      scl = 1'h0;
      w(2);
    end
  endtask
  task sp;
    begin
      sda_m = 1'h0;
      w(3);
      scl = 1'h1;
      w(3);
      sda_m = 1'h1;
      w(4);
    end
  endtask
  // SDA only changes while SCL is low.
  task bx(input b, output r);
    begin
      sda_m = b;
      w(3);
      scl = 1'h1;
      w(2);
      r = sda;
      w(1);
      scl = 1'h0;
      w(2);
    end
  endtask
  // Eight bits MSB first, then the ack clock; am low acks.
  task xb(input [7:0] tx, input am, output [7:0] rx, output ak);
    integer i;
    begin
      for (i = 7; i >= 0; i = i - 1) begin
        bx(tx[i], rx[i]);
      end
      bx(am, ak);
    end
  endtask
endmodule

// *** testbench/rtcis_slave_tb.sv ***
// Self-checking bench for the two-wire slave.
// Assumes the master model and a register core array kept here.
`timescale 1ns/1ps
module rtcis_slave_tb;
  reg clk = 1'h0;
  reg rstn = 1'h0;
  reg wr_ready = 1'h1;
  wire scl, sda_m, sda, sda_o, sda_oe, wr_valid, freeze, wdt_expired;
  wire [3:0] wr_addr, rd_addr;
  wire [7:0] wr_data;
  reg [7:0] regs [0:15];
  wire [7:0] rd_data = regs[rd_addr];
  integer num_errors = 0, compares = 0, cyc = 0, i, n;
  reg [7:0] rx;
  reg ak;
  assign sda = sda_m & ~sda_oe;
  always #10 clk = ~clk;
  rtcis_master mst (.clk(clk), .sda(sda), .scl(scl), .sda_m(sda_m));
  // The watchdog period is cut for simulation but must outlast the longest
  // transfer, about 300 cycles from address to stop.
  rtcis_slave #(.WDT_CYCLES(400)) rtcis_slave_inst (.clk(clk), .rstn(rstn),
    .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_addr(wr_addr),
    .wr_data(wr_data), .rd_addr(rd_addr), .rd_data(rd_data),
    .freeze(freeze), .wdt_expired(wdt_expired));
  // ----------------------------------------------------------------
  // Register core, checking and run control
  // ----------------------------------------------------------------
  // Written at the rising edge at which the slave pops the word, so a
  // change of wr_ready at the falling edge cannot race the write.
  always @(posedge clk) begin
    if (wr_valid && wr_ready) begin
      regs[wr_addr] <= wr_data;
    end
  end
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        num_errors = num_errors + 1;
        $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task end_sim;
    begin
      $display("compares %0d mismatches %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) begin
        $display("NO MISMATCHES");
      end else begin
        $display("MISMATCHES SEEN");
      end
      $finish;
    end
  endtask
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      num_errors = num_errors + 1;
      end_sim;
    end
  end
  task wr_byte(input [7:0] b, input e);
    begin
      mst.xb(b, 1'h1, rx, ak);
      chk(ak, e);
    end
  endtask
  task t_write;
    begin
      mst.st;
      wr_byte(8'hA0, 1'h0);
      chk(freeze, 1'h1);
      wr_byte(8'hF3, 1'h0);
      wr_byte(8'h5A, 1'h0);
      wr_byte(8'hC3, 1'h0);
      mst.sp;
      chk(freeze, 1'h0);
      chk(regs[3], 8'h5A);
      chk(regs[4], 8'hC3);
      $display("write test done");
    end
  endtask
  task t_read;
    begin
      mst.st;
      wr_byte(8'hA1, 1'h0);
      mst.xb(8'hFF, 1'h0, rx, ak);
      chk(rx, 8'h55);
      mst.xb(8'hFF, 1'h1, rx, ak);
      chk(rx, 8'h66);
      mst.w(4);
      chk(sda, 1'h1);
      mst.sp;
      $display("read test done");
    end
  endtask
  task t_addr;
    begin
      mst.st;
      wr_byte(8'hA2, 1'h1);
      wr_byte(8'h00, 1'h1);
      chk(freeze, 1'h0);
      mst.sp;
      $display("address test done");
    end
  endtask
  // A stalled core fills both entries; the third byte must be refused.
  task t_full;
    begin
      wr_ready = 1'h0;
      mst.st;
      wr_byte(8'hA0, 1'h0);
      wr_byte(8'h0E, 1'h0);
      wr_byte(8'h11, 1'h0);
      wr_byte(8'h22, 1'h0);
      wr_byte(8'h33, 1'h1);
      mst.sp;
      chk(wr_valid, 1'h1);
      wr_ready = 1'h1;
      mst.w(6);
      chk(wr_valid, 1'h0);
      chk({regs[14], regs[15]}, 16'h1122);
      mst.st;
      wr_byte(8'hA1, 1'h0);
      mst.xb(8'hFF, 1'h1, rx, ak);
      chk(rx, 8'h00);
      mst.sp;
      $display("buffer test done");
    end
  endtask
  // A stop inside a byte aborts it and disarms the watchdog.
  task t_abort;
    begin
      mst.st;
      wr_byte(8'hA0, 1'h0);
      wr_byte(8'h02, 1'h0);
      for (i = 0; i < 4; i = i + 1) begin
        mst.bx(1'h1, ak);
      end
      mst.w(20);
      mst.sp;
      n = 0;
      for (i = 0; i < 1000; i = i + 1) begin
        @(negedge clk);
        n = n + wdt_expired;
      end
      chk(n, 0);
      chk({freeze, regs[2]}, 9'h022);
      $display("abort test done");
    end
  endtask
  task t_wdt;
    begin
      mst.st;
      wr_byte(8'hA0, 1'h0);
      n = 0;
      while (wdt_expired !== 1'h1 && n < 1000) begin
        @(negedge clk);
        n = n + 1;
      end
      chk(n >= 393 && n <= 795, 1'h1);
      mst.w(2);
      chk({freeze, sda}, 2'h1);
      mst.sp;
      $display("watchdog test done");
    end
  endtask
  initial begin
    for (i = 0; i < 16; i = i + 1) begin
      regs[i] = 8'h11 * i[7:0];
    end
    repeat (12) @(negedge clk);
    chk({sda_o, sda_oe, wr_valid, freeze, wdt_expired}, 5'h0);
    chk({rd_addr, wr_addr, wr_data}, 16'h0);
    rstn = 1'h1;
    repeat (4) @(negedge clk);
    t_write;
    t_read;
    t_addr;
    t_full;
    t_abort;
    t_wdt;
    end_sim;
  end
endmodule
